// ---- include/lbtc_map.svh ----
// Register addresses, field positions, reset values and timing figures
// for the MODE_SELECT_BIT breathing timing controller.
// Assumes inclusion by bare name from the core.
`ifndef LBTC_MAP_SVH
`define LBTC_MAP_SVH

`define LBTC_ADDR_SHUTDOWN   8'h00
`define LBTC_ADDR_BREATH     8'h01
`define LBTC_ADDR_MODE       8'h02
`define LBTC_ADDR_DUTY       8'h04
`define LBTC_ADDR_DUTY_LOAD  8'h07
`define LBTC_ADDR_OFFSET     8'h0A
`define LBTC_ADDR_RISE_HOLD  8'h10
`define LBTC_ADDR_FALL_OFF   8'h16
`define LBTC_ADDR_TIME_LOAD  8'h1C
`define LBTC_ADDR_CHAN_ON    8'h1D
`define LBTC_ADDR_SOFT_RESET 8'h2F

`define LBTC_LOAD_KEY        8'h00

`define LBTC_SSD_BIT         0
`define LBTC_RAMP_BIT        5
`define LBTC_HOLD_SEL_BIT    4
`define LBTC_MODE_BIT        5
`define LBTC_CHAN_ON_BIT     0

`define LBTC_OFFSET_FIELD    7:4
`define LBTC_RISE_FIELD      7:5
`define LBTC_HOLD_FIELD      4:1
`define LBTC_FALL_FIELD      7:5
`define LBTC_OFF_FIELD       4:1
`define LBTC_PEAK_FIELD      7:1

`define LBTC_CODE_MAX_LONG   4'hA
`define LBTC_CODE_MAX_SHORT  4'h8
`define LBTC_DUR_ONE         10'h001
`define LBTC_DUR_ZERO        10'h000
`define LBTC_DUR_MAX_LONG    10'h200
`define LBTC_DUR_MAX_SHORT   10'h080

`define LBTC_RST_SSD         1'b1
`define LBTC_RST_CHAN_ON     1'b1
`define LBTC_RST_BIT         1'b0
`define LBTC_RST_BYTE        8'h00

`define LBTC_TICK_NS         130000000
`define LBTC_CLK_NS          20

`endif

// ---- include/lbtc_pkg.sv ----
// Types shared by the MODE_SELECT_BIT breathing timing controller files.
// Assumes lbtc_map.svh is on the include path.
package lbtc_pkg;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } lbtc_wr_t;

  // Gray along idle, offset, rise, hold, fall, off and back to rise
  typedef enum logic [2:0] {
    LBTC_IDLE   = 3'b000,
    LBTC_OFFSET = 3'b001,
    LBTC_RISE   = 3'b011,
    LBTC_HOLD   = 3'b010,
    LBTC_FALL   = 3'b110,
    LBTC_OFF    = 3'b111
  } lbtc_phase_t;

  typedef struct packed {
    logic       soft_shutdown_bit;
    logic       ramp_en;
    logic       hold_sel;
    logic       mode;
    logic       chan_on;
    logic [7:0] duty_hold;
    logic [7:0] duty;
    logic [7:0] offset_hold;
    logic [7:0] rise_hold_hold;
    logic [7:0] fall_off_hold;
    logic [7:0] offset_act;
    logic [7:0] rise_hold_act;
    logic [7:0] fall_off_act;
  } lbtc_regs_t;

  typedef struct packed {
    lbtc_regs_t  regs;
    lbtc_phase_t phase;
    logic [22:0] base_cnt;
    logic [9:0]  tick_cnt;
    logic [7:0]  level;
  } lbtc_state_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic       out;
  } lbtc_pwm_state_t;

endpackage : lbtc_pkg

// ---- core/lbtc_pwm.sv ----
// 256-step PWM generator for one output.
// Assumes level is stable-ish; a new level takes effect at once.
`timescale 1ns/1ps
`default_nettype none

module lbtc_pwm (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [7:0] level,
  input  wire logic       enable,
  output var  logic       pwm_out
);
  import lbtc_pkg::*;

  lbtc_pwm_state_t st_ff;
  lbtc_pwm_state_t nxt_st;

  always_comb begin
    nxt_st     = st_ff;
    nxt_st.cnt = st_ff.cnt + 8'h01;
    // Level N gives N high counts out of 256; full scale is 255/256
    nxt_st.out = enable && (st_ff.cnt < level);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pwm_out = st_ff.out;

endmodule : lbtc_pwm

`default_nettype wire

// ---- core/lbtc_core.sv ----
// MODE_SELECT_BIT breathing timing controller: register file written by a byte-write
// port (decoded serial writes), direct duty mode and automatic breathing.
// Assumes the write port is synchronous to clk and one write per strobe.
`timescale 1ns/1ps
`default_nettype none
`include "lbtc_map.svh"

// Contract
// - Offset code: zero, then 0.13s doubling to 66.56s
// - Rise code: 0.13s doubling to 16.64s
// - Hold code: zero, then 0.13s doubling to 16.64s
// - Fall code: 0.13s doubling to 16.64s
// - Off code: zero, then 0.13s doubling to 66.56s
// - Time writes held until load strobe of zero
// - Channel-on bit gates output, defaults on
// - Zero written to soft reset restores defaults
// - Power-up loads defaults, output starts dark
// - Direct mode drives duty N of 256
// - Direct duty holds until rewritten
// - Breathing mode varies intensity automatically
// - Offset once, then rise-hold-fall-off repeats
// - Breathing peak from upper seven duty bits
// - Ramping with hold select 0 stays in hold
// - Ramping with hold select 1 stays off
// - Software shutdown bit switches output off
// - Registers kept during either shutdown
// - Low shutdown pin forces hardware shutdown
// - Duty writes held until duty load strobe
// - Mode bit five selects duty or breathing
// - Ramping enable bit five, hold select four
// - Shutdown register bit zero is software shutdown
module lbtc_core #(
  parameter int TICK_CYCLES = (`LBTC_TICK_NS + `LBTC_CLK_NS - 1) / `LBTC_CLK_NS
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire lbtc_pkg::lbtc_wr_t reg_wr,
  input  wire logic              shutdown_n_pin,
  output var  logic              led_out,
  output var  logic [7:0]        led_level,
  output var  lbtc_pkg::lbtc_phase_t phase,
  output var  logic              shutdown_active
);
  import lbtc_pkg::*;

  // Divider wide enough for the whole shortest step at the 50 MHz clock
  localparam logic [22:0] TICK_LAST = 23'(TICK_CYCLES - 1);

  localparam lbtc_regs_t REGS_DEFAULT = '{
    soft_shutdown_bit:            `LBTC_RST_SSD,
    ramp_en:        `LBTC_RST_BIT,
    hold_sel:       `LBTC_RST_BIT,
    mode:           `LBTC_RST_BIT,
    chan_on:        `LBTC_RST_CHAN_ON,
    duty_hold:      `LBTC_RST_BYTE,
    duty:           `LBTC_RST_BYTE,
    offset_hold:    `LBTC_RST_BYTE,
    rise_hold_hold: `LBTC_RST_BYTE,
    fall_off_hold:  `LBTC_RST_BYTE,
    offset_act:     `LBTC_RST_BYTE,
    rise_hold_act:  `LBTC_RST_BYTE,
    fall_off_act:   `LBTC_RST_BYTE
  };

  // Power-up and soft reset share this image, so both start dark
  localparam lbtc_state_t STATE_DEFAULT = '{
    regs:     REGS_DEFAULT,
    phase:    LBTC_IDLE,
    base_cnt: '0,
    tick_cnt: '0,
    level:    '0
  };

  lbtc_state_t st_ff;
  lbtc_state_t nxt_st;

  // Codes with a zero setting: 0 is no time, k is 2^(k-1) ticks.
  // Unavailable codes are clamped to the longest setting.
  function automatic logic [9:0] dur_zeroable(
    input logic [3:0] code,
    input logic [3:0] code_max,
    input logic [9:0] dur_max
  );
    logic [9:0] d;
    d = `LBTC_DUR_ZERO;
    if (code == 4'h0) begin
      d = `LBTC_DUR_ZERO;
    end else if (code > code_max) begin
      d = dur_max;
    end else begin
      d = `LBTC_DUR_ONE << (code - 4'h1);
    end
    return d;
  endfunction : dur_zeroable

  // Ramp codes have no zero setting: code k is 2^k ticks
  function automatic logic [9:0] dur_ramp(input logic [2:0] code);
    return `LBTC_DUR_ONE << code;
  endfunction : dur_ramp

  // Level after cnt of 2^shift ticks of a linear ramp to peak
  function automatic logic [7:0] ramp_level(
    input logic [7:0] peak,
    input logic [9:0] cnt,
    input logic [2:0] shift
  );
    // Wide enough for any peak times any tick count
    logic [17:0] prod;
    prod = {10'h000, peak} * {8'h00, cnt};
    prod = prod >> shift;
    return prod[7:0];
  endfunction : ramp_level

  logic       sw_shutdown;
  logic       hw_shutdown;
  logic       halted;
  logic       tick;
  logic [7:0] peak;
  logic [2:0] rise_code;
  logic [2:0] fall_code;
  logic [9:0] dur_offset;
  logic [9:0] dur_rise;
  logic [9:0] dur_hold;
  logic [9:0] dur_fall;
  logic [9:0] dur_off;
  logic [9:0] dur_cur;
  logic       phase_done;
  logic       stay_hold;
  logic       stay_off;
  logic       time_load;
  logic       duty_load;
  logic       soft_reset;

  always_comb begin
    sw_shutdown = st_ff.regs.soft_shutdown_bit;
    hw_shutdown = !shutdown_n_pin;
    // Either shutdown source darkens the output and freezes the sequencer
    halted      = sw_shutdown || hw_shutdown;

    peak      = {st_ff.regs.duty[`LBTC_PEAK_FIELD], 1'b0};
    rise_code = st_ff.regs.rise_hold_act[`LBTC_RISE_FIELD];
    fall_code = st_ff.regs.fall_off_act[`LBTC_FALL_FIELD];

    dur_offset = dur_zeroable(st_ff.regs.offset_act[`LBTC_OFFSET_FIELD],
                              `LBTC_CODE_MAX_LONG, `LBTC_DUR_MAX_LONG);
    dur_rise   = dur_ramp(rise_code);
    dur_hold   = dur_zeroable(st_ff.regs.rise_hold_act[`LBTC_HOLD_FIELD],
                              `LBTC_CODE_MAX_SHORT, `LBTC_DUR_MAX_SHORT);
    dur_fall   = dur_ramp(fall_code);
    dur_off    = dur_zeroable(st_ff.regs.fall_off_act[`LBTC_OFF_FIELD],
                              `LBTC_CODE_MAX_LONG, `LBTC_DUR_MAX_LONG);

    unique case (st_ff.phase)
      LBTC_OFFSET: dur_cur = dur_offset;
      LBTC_RISE:   dur_cur = dur_rise;
      LBTC_HOLD:   dur_cur = dur_hold;
      LBTC_FALL:   dur_cur = dur_fall;
      LBTC_OFF:    dur_cur = dur_off;
      default:     dur_cur = `LBTC_DUR_ZERO;
    endcase

    // Divider restarts with every phase, so each phase gets whole ticks;
    // a phase lasts one clock longer than its tick count
    tick       = (st_ff.base_cnt == TICK_LAST);
    phase_done = (st_ff.tick_cnt >= dur_cur);
    // Held phases keep their tick count, so clearing ramping resumes them
    stay_hold  = st_ff.regs.ramp_en && !st_ff.regs.hold_sel;
    stay_off   = st_ff.regs.ramp_en && st_ff.regs.hold_sel;

    time_load  = reg_wr.wr && (reg_wr.addr == `LBTC_ADDR_TIME_LOAD)
                 && (reg_wr.data == `LBTC_LOAD_KEY);
    duty_load  = reg_wr.wr && (reg_wr.addr == `LBTC_ADDR_DUTY_LOAD)
                 && (reg_wr.data == `LBTC_LOAD_KEY);
    soft_reset = reg_wr.wr && (reg_wr.addr == `LBTC_ADDR_SOFT_RESET)
                 && (reg_wr.data == `LBTC_LOAD_KEY);
  end

  always_comb begin
    nxt_st = st_ff;

    // Register writes; shutdown does not touch stored contents
    if (reg_wr.wr) begin
      unique case (reg_wr.addr)
        `LBTC_ADDR_SHUTDOWN: begin
          nxt_st.regs.soft_shutdown_bit = reg_wr.data[`LBTC_SSD_BIT];
        end
        `LBTC_ADDR_BREATH: begin
          nxt_st.regs.ramp_en  = reg_wr.data[`LBTC_RAMP_BIT];
          nxt_st.regs.hold_sel = reg_wr.data[`LBTC_HOLD_SEL_BIT];
        end
        `LBTC_ADDR_MODE: begin
          nxt_st.regs.mode = reg_wr.data[`LBTC_MODE_BIT];
        end
        `LBTC_ADDR_DUTY: begin
          nxt_st.regs.duty_hold = reg_wr.data;
        end
        `LBTC_ADDR_OFFSET: begin
          nxt_st.regs.offset_hold = reg_wr.data;
        end
        `LBTC_ADDR_RISE_HOLD: begin
          nxt_st.regs.rise_hold_hold = reg_wr.data;
        end
        `LBTC_ADDR_FALL_OFF: begin
          nxt_st.regs.fall_off_hold = reg_wr.data;
        end
        `LBTC_ADDR_CHAN_ON: begin
          nxt_st.regs.chan_on = reg_wr.data[`LBTC_CHAN_ON_BIT];
        end
        default: begin
        end
      endcase
    end

    if (duty_load) begin
      nxt_st.regs.duty = st_ff.regs.duty_hold;
    end

    // Sequencer
    if (!st_ff.regs.mode) begin
      // Direct duty: level follows the loaded duty and nothing else
      nxt_st.phase    = LBTC_IDLE;
      nxt_st.base_cnt = '0;
      nxt_st.tick_cnt = '0;
      nxt_st.level    = st_ff.regs.duty;
    end else if (!halted) begin
      // Frozen while shut down so leaving shutdown resumes in place
      nxt_st.base_cnt = tick ? 23'h000000 : st_ff.base_cnt + 23'h000001;
      if (st_ff.phase == LBTC_IDLE) begin
        nxt_st.phase    = LBTC_OFFSET;
        nxt_st.base_cnt = '0;
        nxt_st.tick_cnt = '0;
      end else if ((st_ff.phase == LBTC_HOLD && stay_hold)
                   || (st_ff.phase == LBTC_OFF && stay_off)) begin
        nxt_st.tick_cnt = st_ff.tick_cnt;
      end else if (phase_done) begin
        nxt_st.base_cnt = '0;
        nxt_st.tick_cnt = '0;
        unique case (st_ff.phase)
          LBTC_OFFSET: nxt_st.phase = LBTC_RISE;
          LBTC_RISE:   nxt_st.phase = LBTC_HOLD;
          LBTC_HOLD:   nxt_st.phase = LBTC_FALL;
          LBTC_FALL:   nxt_st.phase = LBTC_OFF;
          default:     nxt_st.phase = LBTC_RISE;
        endcase
      end else if (tick) begin
        nxt_st.tick_cnt = st_ff.tick_cnt + 10'h001;
      end

      // Level lags the phase by one clock
      unique case (st_ff.phase)
        LBTC_RISE: nxt_st.level = ramp_level(peak, st_ff.tick_cnt, rise_code);
        LBTC_HOLD: nxt_st.level = peak;
        LBTC_FALL: nxt_st.level = peak - ramp_level(peak, st_ff.tick_cnt, fall_code);
        default:   nxt_st.level = '0;
      endcase
    end

    // New timing restarts breathing from the offset phase
    if (time_load) begin
      nxt_st.regs.offset_act    = st_ff.regs.offset_hold;
      nxt_st.regs.rise_hold_act = st_ff.regs.rise_hold_hold;
      nxt_st.regs.fall_off_act  = st_ff.regs.fall_off_hold;
      nxt_st.phase              = LBTC_IDLE;
      nxt_st.base_cnt           = '0;
      nxt_st.tick_cnt           = '0;
    end

    // Soft reset last so it overrides any other update this cycle
    if (soft_reset) begin
      nxt_st = STATE_DEFAULT;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_ff <= STATE_DEFAULT;
    end else begin
      st_ff <= nxt_st;
    end
  end

  logic pwm_enable;

  // Channel-on gates only the output; the sequencer keeps its place
  // so switching the channel back on resumes the current phase
  assign pwm_enable = st_ff.regs.chan_on && !sw_shutdown && !hw_shutdown;

  lbtc_pwm lbtc_pwm_inst (
    .clk     (clk),
    .reset   (reset),
    .level   (st_ff.level),
    .enable  (pwm_enable),
    .pwm_out (led_out)
  );

  assign led_level       = st_ff.level;
  assign phase           = st_ff.phase;
  // Combinational so the pin acts without waiting for a clock
  assign shutdown_active = halted;

endmodule : lbtc_core

`default_nettype wire

// ---- testbench/lbtc_checker.sv ----
// Port assertions for the MODE_SELECT_BIT breathing timing controller.
// Assumes binding onto lbtc_core; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module lbtc_checker #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic                  clk,
  input wire logic                  reset,
  input wire lbtc_pkg::lbtc_wr_t    reg_wr,
  input wire logic                  shutdown_n_pin,
  input wire logic                  led_out,
  input wire logic [7:0]            led_level,
  input wire lbtc_pkg::lbtc_phase_t phase,
  input wire logic                  shutdown_active
);
  import lbtc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_pin; !shutdown_n_pin |-> shutdown_active; endproperty
  a_pin: assert property (p_pin) else $error("pin low without shutdown");
  property p_sd_dark; $rose(shutdown_active) |-> ##[1:2] !led_out; endproperty
  a_sd_dark: assert property (p_sd_dark) else $error("output lit in shutdown");
  property p_rst; $fell(reset) |-> led_level == 8'h00 && phase == LBTC_IDLE; endproperty
  a_rst: assert property (p_rst) else $error("not dark after reset");
  // Writes excluded: a time load may restart the sequencer
  property p_freeze;
    shutdown_active && !reg_wr.wr ##1 shutdown_active |-> $stable(phase);
  endproperty
  a_freeze: assert property (p_freeze) else $error("phase moved in shutdown");
  property p_rise_from;
    $changed(phase) && phase == LBTC_RISE |-> $past(phase) inside {LBTC_OFFSET, LBTC_OFF};
  endproperty
  a_rise_from: assert property (p_rise_from) else $error("bad entry to rise");
  property p_offset_from;
    $changed(phase) && phase == LBTC_OFFSET |-> $past(phase) == LBTC_IDLE;
  endproperty
  a_offset_from: assert property (p_offset_from) else $error("offset repeated");
  property p_off_dark; phase == LBTC_OFF ##1 phase == LBTC_OFF |-> led_level == 8'h00; endproperty
  a_off_dark: assert property (p_off_dark) else $error("level not zero in off");
  property p_hold_even; phase == LBTC_HOLD [*2] |-> led_level[0] == 1'b0; endproperty
  a_hold_even: assert property (p_hold_even) else $error("peak uses low duty bit");
  c_hold: cover property (phase == LBTC_HOLD [*8]);
  c_off: cover property (phase == LBTC_OFF [*8]);
  c_sd: cover property ($fell(shutdown_n_pin));
endmodule : lbtc_checker

bind lbtc_core lbtc_checker #(.TICK_CYCLES(TICK_CYCLES)) lbtc_checker_inst (
  .clk(clk), .reset(reset), .reg_wr(reg_wr), .shutdown_n_pin(shutdown_n_pin),
  .led_out(led_out), .led_level(led_level), .phase(phase),
  .shutdown_active(shutdown_active));
`default_nettype wire

// ---- testbench/lbtc_host.sv ----
// Register host: issues one-byte writes on the write port.
// Assumes the bench calls put from a single process.
`timescale 1ns/1ps
`default_nettype none
module lbtc_host (
  input  wire logic               clk,
  output var  lbtc_pkg::lbtc_wr_t reg_wr
);
  import lbtc_pkg::*;
  initial reg_wr = '0;
  // Loads are only a write of key 00h; values are rewritten as needed
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= '{wr: 1'b1, addr: a, data: d};
    @(posedge clk);
    reg_wr.wr <= 1'b0;
  endtask : put
endmodule : lbtc_host
`default_nettype wire

// ---- testbench/lbtc_core_bench.sv ----
// Self-checking bench: direct duty, shutdown, soft reset, breathing.
// Assumes lbtc_pkg, lbtc_host and lbtc_checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module lbtc_core_bench;
  import lbtc_pkg::*;
  logic        clk;
  logic        reset;
  logic        shutdown_n_pin;
  logic        led_out;
  logic        shutdown_active;
  logic [7:0]  led_level;
  logic [7:0]  exp_level;
  logic [7:0]  n;
  logic [31:0] rnd;
  lbtc_wr_t    reg_wr;
  lbtc_phase_t phase;
  lbtc_phase_t seen[$];
  lbtc_phase_t want[7] = '{LBTC_OFFSET, LBTC_RISE, LBTC_HOLD, LBTC_FALL, LBTC_OFF,
                           LBTC_RISE, LBTC_HOLD};
  int          error_cnt;
  int          cmp_count;
  int          rises;
  int          len;
  lbtc_phase_t held;

  localparam int TICK = 4;

  lbtc_core #(.TICK_CYCLES(TICK)) lbtc_core_inst (
    .clk(clk), .reset(reset), .reg_wr(reg_wr), .shutdown_n_pin(shutdown_n_pin),
    .led_out(led_out), .led_level(led_level), .phase(phase),
    .shutdown_active(shutdown_active));
  lbtc_host lbtc_host_inst (.clk(clk), .reg_wr(reg_wr));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    lbtc_host_inst.put(a, d);
    cyc(3);
  endtask : wr

  // A steady level gives exactly level highs in any 256-cycle window
  task automatic highs();
    n = 8'h00;
    cyc(4);
    repeat (256) begin
      @(negedge clk);
      n = n + 8'(led_out);
    end
  endtask : highs

  // Tick tables: zero code is no time, oversize codes clamp to longest
  function automatic int zt(input int k, input int kmax);
    return (k == 0) ? 0 : 1 << ((k > kmax ? kmax : k) - 1);
  endfunction : zt

  // Clocks per phase: whole ticks plus one clock to move on
  function automatic int plen(input int t);
    return TICK * t + 1;
  endfunction : plen

  // Clocks spent in phase p on its next visit, bounded
  task automatic span(input lbtc_phase_t p, output int l);
    l = 0;
    for (int k = 0; k < 4000 && phase != p; k++) @(negedge clk);
    while (phase == p && l < 4000) begin
      @(negedge clk);
      l++;
    end
  endtask : span

  task automatic watch();
    seen.delete();
    rises = 0;
    repeat (100) begin
      @(negedge clk);
      if (phase != LBTC_IDLE && (seen.size() == 0 || seen[$] != phase)) begin
        seen.push_back(phase);
        rises += int'(phase == LBTC_RISE);
      end
    end
  endtask : watch

  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    #800us;
    error_cnt++;
    end_sim();
  end

  initial begin
    reset = 1'b1;
    shutdown_n_pin = 1'b1;
    error_cnt = 0;
    cmp_count = 0;
    exp_level = 8'h00;
    rnd = 32'h007E3D75;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    cyc(1);
    chk(led_level, 8'h00);
    chk(8'(phase), 8'(LBTC_IDLE));
    chk(8'(shutdown_active), 8'h01);
    $display("reset test done");
    wr(8'h00, 8'h00);
    chk(8'(shutdown_active), 8'h00);
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      wr(8'h04, (i == 0) ? 8'h04 : rnd[7:0]);
      wr(8'h07, 8'h01);
      chk(led_level, exp_level);
      wr(8'h07, 8'h00);
      exp_level = (i == 0) ? 8'h04 : rnd[7:0];
      chk(led_level, exp_level);
      highs();
      chk(n, exp_level);
      highs();
      chk(n, exp_level);
    end
    wr(8'h1D, 8'h00);
    highs();
    chk(n, 8'h00);
    wr(8'h1D, 8'h01);
    wr(8'h00, 8'h01);
    highs();
    chk(n, 8'h00);
    wr(8'h00, 8'h00);
    highs();
    chk(n, exp_level);
    @(posedge clk);
    shutdown_n_pin <= 1'b0;
    highs();
    chk(8'(shutdown_active), 8'h01);
    chk(n, 8'h00);
    @(posedge clk);
    shutdown_n_pin <= 1'b1;
    highs();
    chk(n, exp_level);
    $display("direct and shutdown tests done");
    wr(8'h2F, 8'h00);
    chk(8'(shutdown_active), 8'h01);
    chk(led_level, 8'h00);
    $display("soft reset test done");
    wr(8'h00, 8'h00);
    wr(8'h04, 8'hFF);
    wr(8'h07, 8'h00);
    wr(8'h0A, 8'h10);
    wr(8'h10, 8'h02);
    wr(8'h16, 8'h02);
    wr(8'h1C, 8'h00);
    lbtc_host_inst.put(8'h02, 8'h20);
    watch();
    foreach (want[i]) chk(8'(seen[i]), 8'(want[i]));
    // Long rise written but never loaded: cycle must stay short
    wr(8'h10, 8'hE0);
    watch();
    chk(8'(rises >= 2), 8'h01);
    // Shutdown mid-cycle: phase freezes in place, output dark
    wr(8'h00, 8'h01);
    held = phase;
    cyc(40);
    chk(8'(phase), 8'(held));
    chk(8'(led_out), 8'h00);
    wr(8'h00, 8'h00);
    wr(8'h01, 8'h20);
    cyc(100);
    chk(8'(phase), 8'(LBTC_HOLD));
    chk(led_level, 8'hFE);
    cyc(200);
    chk(8'(phase), 8'(LBTC_HOLD));
    wr(8'h01, 8'h30);
    cyc(100);
    chk(8'(phase), 8'(LBTC_OFF));
    chk(led_level, 8'h00);
    wr(8'h02, 8'h00);
    chk(8'(phase), 8'(LBTC_IDLE));
    chk(led_level, 8'hFF);
    $display("breathing tests done");
    wr(8'h01, 8'h00);
    wr(8'h0A, 8'h20);
    wr(8'h10, 8'h52);
    wr(8'h16, 8'h20);
    wr(8'h1C, 8'h00);
    lbtc_host_inst.put(8'h02, 8'h20);
    span(LBTC_OFFSET, len);
    chk(8'(len == plen(zt(2, 10))), 8'h01);
    span(LBTC_RISE, len);
    chk(8'(len == plen(1 << 2)), 8'h01);
    span(LBTC_HOLD, len);
    chk(8'(len == plen(zt(9, 8))), 8'h01);
    span(LBTC_FALL, len);
    chk(8'(len == plen(1 << 1)), 8'h01);
    span(LBTC_OFF, len);
    chk(8'(len == plen(zt(0, 10))), 8'h01);
    $display("timing tests done");
    end_sim();
  end
endmodule : lbtc_core_bench
`default_nettype wire
